// ==== core/dcrv_top.sv ====
// Overview of operation
// - Left converter powered up when setup bit7 set.
// - Right converter powered up when setup bit6 set.
// - Left source: off, left, right, or average.
// - Right source: off, right, left, or average.
// - Soft-step: every sample, every two, or none.
// - Left channel muted while bit3 set; reset muted.
// - Right channel muted while bit2 set; reset muted.
// - Link field copies one gain to other channel while dynamic_range_compression_en is low.
// - Gain is signed code in half-decibel steps.
// - Both gains reset to code zero, 0 dB.
// - Right gain encoded like left, sets right.
`timescale 1ns/1ps
`default_nettype none
module dcrv_top
   import dcrv_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire dcrv_reg_req_type reg_req,
   output logic [DATA_W-1:0]     reg_rdata,
   output logic                  reg_rd_valid,
   input  wire logic             dynamic_range_compression_en,
   input  wire logic             sample_valid,
   input  wire dcrv_stereo_type  sample_in,
   output dcrv_stereo_type       sample_out,
   output logic                  sample_out_valid,
   output logic                  left_power_up,
   output logic                  right_power_up
);

   // ****************************************************************
   // Source selection shared by both channels
   // ****************************************************************
   function automatic logic signed [SAMPLE_W-1:0] dcrv_route(
      input dcrv_src_type               sel,
      input logic signed [SAMPLE_W-1:0] own,
      input logic signed [SAMPLE_W-1:0] other,
      input logic signed [SAMPLE_W-1:0] mix
   );
      case (sel)
         SRC_OFF:    dcrv_route = '0;
         SRC_DIRECT: dcrv_route = own;
         SRC_SWAP:   dcrv_route = other;
         SRC_MIX:    dcrv_route = mix;
         default:    dcrv_route = '0;
      endcase
   endfunction

   // Silences a channel that is powered down or muted.
   function automatic logic signed [SAMPLE_W-1:0] dcrv_gate(
      input logic                       pass,
      input logic signed [SAMPLE_W-1:0] value
   );
      dcrv_gate = pass ? value : '0;
   endfunction

   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic rst_meta_ff;
   logic rst_sync_ff;
   logic rst_sync_n;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   assign rst_sync_n = rst_sync_ff;

   // ****************************************************************
   // Register file
   // ****************************************************************
   logic [DATA_W-1:0]      path_setup_ff;
   logic [DATA_W-1:0]      nxt_path_setup;
   logic [MUTE_LINK_W-1:0] mute_link_ff;
   logic [MUTE_LINK_W-1:0] nxt_mute_link;
   logic [DATA_W-1:0]      left_gain_ff;
   logic [DATA_W-1:0]      nxt_left_gain;
   logic [DATA_W-1:0]      right_gain_ff;
   logic [DATA_W-1:0]      nxt_right_gain;

   always_comb begin
      nxt_path_setup = path_setup_ff;
      nxt_mute_link  = mute_link_ff;
      nxt_left_gain  = left_gain_ff;
      nxt_right_gain = right_gain_ff;
      if (reg_req.wr_en) begin
         case (reg_req.addr)
            ADDR_PATH_SETUP: begin
               nxt_path_setup = reg_req.wdata;
            end
            ADDR_MUTE_LINK: begin
               // Upper bits are not stored and read back as zero.
               nxt_mute_link = reg_req.wdata[MUTE_LINK_W-1:0];
            end
            ADDR_LEFT_GAIN: begin
               nxt_left_gain = reg_req.wdata;
            end
            ADDR_RIGHT_GAIN: begin
               nxt_right_gain = reg_req.wdata;
            end
            default: begin
               nxt_path_setup = path_setup_ff;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         path_setup_ff <= PATH_SETUP_RST;
         mute_link_ff  <= MUTE_LINK_RST;
         left_gain_ff  <= GAIN_RST;
         right_gain_ff <= GAIN_RST;
      end else begin
         path_setup_ff <= nxt_path_setup;
         mute_link_ff  <= nxt_mute_link;
         left_gain_ff  <= nxt_left_gain;
         right_gain_ff <= nxt_right_gain;
      end
   end

   // ****************************************************************
   // Register read-back
   // ****************************************************************
   logic [DATA_W-1:0] rdata_ff;
   logic [DATA_W-1:0] nxt_rdata;
   logic              rd_valid_ff;
   logic              nxt_rd_valid;

   always_comb begin
      nxt_rd_valid = reg_req.rd_en;
      nxt_rdata    = rdata_ff;
      if (reg_req.rd_en) begin
         case (reg_req.addr)
            ADDR_PATH_SETUP: nxt_rdata = path_setup_ff;
            ADDR_MUTE_LINK:  nxt_rdata = {4'h0, mute_link_ff};
            ADDR_LEFT_GAIN:  nxt_rdata = left_gain_ff;
            ADDR_RIGHT_GAIN: nxt_rdata = right_gain_ff;
            default:         nxt_rdata = RDATA_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rdata_ff    <= RDATA_UNMAPPED;
         rd_valid_ff <= 1'b0;
      end else begin
         rdata_ff    <= nxt_rdata;
         rd_valid_ff <= nxt_rd_valid;
      end
   end

   // ****************************************************************
   // Field decode
   // ****************************************************************
   dcrv_src_type  left_src;
   dcrv_src_type  right_src;
   dcrv_step_type step_mode;
   dcrv_link_type link_mode;
   logic          left_pass;
   logic          right_pass;

   assign left_src   = dcrv_src_type'(path_setup_ff[LSRC_LSB+:2]);
   assign right_src  = dcrv_src_type'(path_setup_ff[RSRC_LSB+:2]);
   assign step_mode  = dcrv_step_type'(path_setup_ff[STEP_LSB+:2]);
   assign link_mode  = dcrv_link_type'(mute_link_ff[LINK_LSB+:2]);
   assign left_pass  = path_setup_ff[PWR_L_BIT] && !mute_link_ff[MUTE_L_BIT];
   assign right_pass = path_setup_ff[PWR_R_BIT] && !mute_link_ff[MUTE_R_BIT];

   // ****************************************************************
   // Volume link
   // ****************************************************************
   logic [DATA_W-1:0] left_target;
   logic [DATA_W-1:0] right_target;

   always_comb begin
      left_target  = left_gain_ff;
      right_target = right_gain_ff;
      if (!dynamic_range_compression_en) begin
         case (link_mode)
            LINK_R_TO_L: left_target = right_gain_ff;
            LINK_L_TO_R: right_target = left_gain_ff;
            default:     left_target = left_gain_ff;
         endcase
      end
   end

   // ****************************************************************
   // Soft-step pacing
   // ****************************************************************
   // The reserved step code is handled like stepping off, so a stray
   // write never freezes the gain short of its target.
   logic phase_ff;
   logic nxt_phase;
   logic step_tick;
   logic step_bypass;

   always_comb begin
      nxt_phase   = sample_valid ? !phase_ff : phase_ff;
      step_bypass = 1'b0;
      step_tick   = 1'b0;
      case (step_mode)
         STEP_EVERY:     step_tick = sample_valid;
         STEP_EVERY_TWO: step_tick = sample_valid && phase_ff;
         STEP_NONE:      step_bypass = 1'b1;
         STEP_RSVD:      step_bypass = 1'b1;
         default:        step_bypass = 1'b1;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         phase_ff <= 1'b0;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   // ****************************************************************
   // Source routing
   // ****************************************************************
   dcrv_stereo_type            routed_ff;
   dcrv_stereo_type            nxt_routed;
   logic                       routed_valid_ff;
   logic                       nxt_routed_valid;
   logic signed [SAMPLE_W:0]   mix_sum;
   logic signed [SAMPLE_W-1:0] mix_avg;

   always_comb begin
      mix_sum          = 17'(sample_in.left + sample_in.right);
      mix_avg          = mix_sum[SAMPLE_W:1];
      nxt_routed       = routed_ff;
      nxt_routed_valid = sample_valid;
      if (sample_valid) begin
         nxt_routed.left  = dcrv_route(left_src, sample_in.left, sample_in.right, mix_avg);
         nxt_routed.right = dcrv_route(right_src, sample_in.right, sample_in.left, mix_avg);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         routed_ff       <= '0;
         routed_valid_ff <= 1'b0;
      end else begin
         routed_ff       <= nxt_routed;
         routed_valid_ff <= nxt_routed_valid;
      end
   end

   // ****************************************************************
   // Gain per channel
   // ****************************************************************
   logic                       gained_valid;
   logic signed [SAMPLE_W-1:0] gained_left;
   logic signed [SAMPLE_W-1:0] gained_right;

   dcrv_gain_stage u_left_gain (
      .sys_clk      (sys_clk),
      .rst_sync_n   (rst_sync_n),
      .step_tick    (step_tick),
      .step_bypass  (step_bypass),
      .target_code  (left_target),
      .in_valid     (routed_valid_ff),
      .in_sample    (routed_ff.left),
      .out_valid    (gained_valid),
      .out_sample   (gained_left),
      .applied_code ()
   );

   dcrv_gain_stage u_right_gain (
      .sys_clk      (sys_clk),
      .rst_sync_n   (rst_sync_n),
      .step_tick    (step_tick),
      .step_bypass  (step_bypass),
      .target_code  (right_target),
      .in_valid     (routed_valid_ff),
      .in_sample    (routed_ff.right),
      .out_valid    (),
      .out_sample   (gained_right),
      .applied_code ()
   );

   // ****************************************************************
   // Output stage
   // ****************************************************************
   // Mute acts at once on the next sample; it does not ramp.
   dcrv_stereo_type out_ff;
   dcrv_stereo_type nxt_out;
   logic            out_valid_ff;
   logic            nxt_out_valid;

   always_comb begin
      nxt_out       = out_ff;
      nxt_out_valid = gained_valid;
      if (gained_valid) begin
         nxt_out.left  = dcrv_gate(left_pass, gained_left);
         nxt_out.right = dcrv_gate(right_pass, gained_right);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         out_ff       <= '0;
         out_valid_ff <= 1'b0;
      end else begin
         out_ff       <= nxt_out;
         out_valid_ff <= nxt_out_valid;
      end
   end

   assign sample_out       = out_ff;
   assign sample_out_valid = out_valid_ff;
   assign reg_rdata        = rdata_ff;
   assign reg_rd_valid     = rd_valid_ff;
   assign left_power_up    = path_setup_ff[PWR_L_BIT];
   assign right_power_up   = path_setup_ff[PWR_R_BIT];

endmodule
`default_nettype wire

// ==== core/dcrv_pkg.sv ====
package dcrv_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int unsigned ADDR_W   = 7;
   localparam int unsigned DATA_W   = 8;
   localparam int unsigned SAMPLE_W = 16;

   // ****************************************************************
   // Register offsets, field positions and reset values
   // ****************************************************************
   localparam logic [ADDR_W-1:0] ADDR_PATH_SETUP  = 7'h3f;
   localparam logic [ADDR_W-1:0] ADDR_MUTE_LINK   = 7'h40;
   localparam logic [ADDR_W-1:0] ADDR_LEFT_GAIN   = 7'h41;
   localparam logic [ADDR_W-1:0] ADDR_RIGHT_GAIN  = 7'h42;

   localparam int unsigned PWR_L_BIT  = 7;
   localparam int unsigned PWR_R_BIT  = 6;
   localparam int unsigned LSRC_LSB   = 4;
   localparam int unsigned RSRC_LSB   = 2;
   localparam int unsigned STEP_LSB   = 0;
   localparam int unsigned MUTE_L_BIT = 3;
   localparam int unsigned MUTE_R_BIT = 2;
   localparam int unsigned LINK_LSB   = 0;
   localparam int unsigned MUTE_LINK_W = 4;

   localparam logic [DATA_W-1:0]      PATH_SETUP_RST = 8'h14;
   localparam logic [MUTE_LINK_W-1:0] MUTE_LINK_RST  = 4'hc;
   localparam logic [DATA_W-1:0]      GAIN_RST       = 8'h00;
   localparam logic [DATA_W-1:0]      RDATA_UNMAPPED = 8'h00;

   // ****************************************************************
   // Gain arithmetic: twelve half-decibel codes per octave of gain
   // ****************************************************************
   localparam logic signed [8:0] GAIN_CODE_OFFSET = 9'sh084;
   localparam logic [8:0]        GAIN_PER_OCTAVE  = 9'h00c;
   localparam logic [5:0]        GAIN_SHIFT_BASE  = 6'h1a;
   localparam int unsigned       MANT_W           = 16;

   // ****************************************************************
   // Modes
   // ****************************************************************
   typedef enum logic [1:0] {SRC_OFF, SRC_DIRECT, SRC_SWAP, SRC_MIX} dcrv_src_type;
   typedef enum logic [1:0] {STEP_EVERY, STEP_EVERY_TWO, STEP_NONE, STEP_RSVD} dcrv_step_type;
   typedef enum logic [1:0] {LINK_INDEP, LINK_R_TO_L, LINK_L_TO_R, LINK_INDEP_ALT} dcrv_link_type;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic signed [SAMPLE_W-1:0] left;
      logic signed [SAMPLE_W-1:0] right;
   } dcrv_stereo_type;

   typedef struct packed {
      logic              wr_en;
      logic              rd_en;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dcrv_reg_req_type;

   function automatic logic signed [SAMPLE_W-1:0] dcrv_sat(input logic signed [32:0] value);
      logic signed [32:0] max_v;
      logic signed [32:0] min_v;
      max_v = 33'sh0_0000_7fff;
      min_v = -33'sh0_0000_8000;
      if (value > max_v) begin
         dcrv_sat = 16'sh7fff;
      end else if (value < min_v) begin
         dcrv_sat = -16'sh8000;
      end else begin
         dcrv_sat = value[SAMPLE_W-1:0];
      end
   endfunction

endpackage

// ==== core/dcrv_gain_stage.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcrv_gain_stage
   import dcrv_pkg::*;
(
   input  wire logic                       sys_clk,
   input  wire logic                       rst_sync_n,
   input  wire logic                       step_tick,
   input  wire logic                       step_bypass,
   input  wire logic [DATA_W-1:0]          target_code,
   input  wire logic                       in_valid,
   input  wire logic signed [SAMPLE_W-1:0] in_sample,
   output logic                            out_valid,
   output logic signed [SAMPLE_W-1:0]      out_sample,
   output logic [DATA_W-1:0]               applied_code
);

   // ****************************************************************
   // Mantissa of 2^(k/12) in Q1.15
   // ****************************************************************
   function automatic logic [MANT_W-1:0] dcrv_mant(input logic [3:0] k);
      case (k)
         4'h0:    dcrv_mant = 16'h8000;
         4'h1:    dcrv_mant = 16'h879c;
         4'h2:    dcrv_mant = 16'h8fad;
         4'h3:    dcrv_mant = 16'h9838;
         4'h4:    dcrv_mant = 16'ha145;
         4'h5:    dcrv_mant = 16'haadc;
         4'h6:    dcrv_mant = 16'hb505;
         4'h7:    dcrv_mant = 16'hbfc9;
         4'h8:    dcrv_mant = 16'hcb30;
         4'h9:    dcrv_mant = 16'hd745;
         4'ha:    dcrv_mant = 16'he412;
         4'hb:    dcrv_mant = 16'hf1a2;
         default: dcrv_mant = 16'h8000;
      endcase
   endfunction

   logic [DATA_W-1:0]          code_ff;
   logic [DATA_W-1:0]          nxt_code;
   logic                       valid_ff;
   logic                       nxt_valid;
   logic signed [SAMPLE_W-1:0] sample_ff;
   logic signed [SAMPLE_W-1:0] nxt_sample;
   logic [8:0]                 biased;
   logic [8:0]                 octave;
   logic [8:0]                 step_in_oct;
   logic [5:0]                 shift;
   logic signed [32:0]         product;

   // ****************************************************************
   // Applied gain, walking toward the target
   // ****************************************************************
   always_comb begin
      nxt_code = code_ff;
      if (step_bypass) begin
         nxt_code = target_code;
      end else if (step_tick && (code_ff != target_code)) begin
         if ($signed(code_ff) < $signed(target_code)) begin
            nxt_code = code_ff + 8'h01;
         end else begin
            nxt_code = code_ff - 8'h01;
         end
      end
   end

   // ****************************************************************
   // Code to linear gain and product
   // ****************************************************************
   // Octaves are taken as 6 dB, so the gain error grows to about 0.24 %
   // per octave; this spares a full 256-entry table.
   always_comb begin
      biased      = 9'($signed({code_ff[DATA_W-1], code_ff}) + GAIN_CODE_OFFSET);
      octave      = biased / GAIN_PER_OCTAVE;
      step_in_oct = biased % GAIN_PER_OCTAVE;
      shift       = GAIN_SHIFT_BASE - octave[5:0];
      product     = 33'(in_sample * $signed({1'b0, dcrv_mant(step_in_oct[3:0])}));
      nxt_valid   = in_valid;
      nxt_sample  = sample_ff;
      if (in_valid) begin
         nxt_sample = dcrv_sat(product >>> shift);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         code_ff   <= GAIN_RST;
         valid_ff  <= 1'b0;
         sample_ff <= '0;
      end else begin
         code_ff   <= nxt_code;
         valid_ff  <= nxt_valid;
         sample_ff <= nxt_sample;
      end
   end

   assign out_valid    = valid_ff;
   assign out_sample   = sample_ff;
   assign applied_code = code_ff;

endmodule
`default_nettype wire

// ==== testbench/dcrv_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcrv_top_sva
   import dcrv_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              rst_n,
   input wire dcrv_reg_req_type  reg_req,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic              reg_rd_valid,
   input wire logic              dynamic_range_compression_en,
   input wire logic              sample_valid,
   input wire dcrv_stereo_type   sample_in,
   input wire dcrv_stereo_type   sample_out,
   input wire logic              sample_out_valid,
   input wire logic              left_power_up,
   input wire logic              right_power_up
);
   // ****************************************************************
   // Shadow registers, so outputs can be tied to what was written.
   // ****************************************************************
   logic [DATA_W-1:0] setup_ff;
   logic [DATA_W-1:0] gl_ff;
   logic [DATA_W-1:0] gr_ff;
   logic [1:0]        mute_ff;
   logic [DATA_W-1:0] nxt_setup;
   logic [DATA_W-1:0] nxt_gl;
   logic [DATA_W-1:0] nxt_gr;
   logic [1:0]        nxt_mute;
   wire logic         wr_setup = reg_req.wr_en && reg_req.addr == ADDR_PATH_SETUP;

   always_comb begin
      nxt_setup = wr_setup ? reg_req.wdata : setup_ff;
      nxt_gl = (reg_req.wr_en && reg_req.addr == ADDR_LEFT_GAIN) ? reg_req.wdata : gl_ff;
      nxt_gr = (reg_req.wr_en && reg_req.addr == ADDR_RIGHT_GAIN) ? reg_req.wdata : gr_ff;
      nxt_mute = (reg_req.wr_en && reg_req.addr == ADDR_MUTE_LINK) ? reg_req.wdata[3:2] : mute_ff;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         setup_ff <= 8'h14;
         gl_ff <= 8'h00;
         gr_ff <= 8'h00;
         mute_ff <= 2'h3;
      end else begin
         setup_ff <= nxt_setup;
         gl_ff <= nxt_gl;
         gr_ff <= nxt_gr;
         mute_ff <= nxt_mute;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   pwr_left_a: assert property (wr_setup |=> left_power_up == $past(reg_req.wdata[7]))
      else $error("left power does not follow setup write");
   pwr_right_a: assert property (wr_setup |=> right_power_up == $past(reg_req.wdata[6]))
      else $error("right power does not follow setup write");
   down_left_a: assert property (sample_out_valid && !$past(left_power_up) |-> sample_out.left == '0)
      else $error("powered down left channel not silent");
   mute_left_a: assert property (sample_out_valid && $past(mute_ff[1]) |-> sample_out.left == '0)
      else $error("muted left channel not silent");
   mute_right_a: assert property (sample_out_valid && $past(mute_ff[0]) |-> sample_out.right == '0)
      else $error("muted right channel not silent");
   off_left_a: assert property (sample_out_valid && !$past(setup_ff[5:4], 3) |-> sample_out.left == '0)
      else $error("left path off but output not silent");
   off_right_a: assert property (sample_out_valid && !$past(setup_ff[3:2], 3) |-> sample_out.right == '0)
      else $error("right path off but output not silent");
   gain_left_a: assert property (reg_req.rd_en && reg_req.addr == ADDR_LEFT_GAIN
      |=> reg_rd_valid && reg_rdata == $past(gl_ff))
      else $error("left gain readback wrong");
   gain_right_a: assert property (reg_req.rd_en && reg_req.addr == ADDR_RIGHT_GAIN
      |=> reg_rd_valid && reg_rdata == $past(gr_ff))
      else $error("right gain readback wrong");
endmodule
`default_nettype wire

// ==== testbench/dcrv_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcrv_top_tb
   import dcrv_pkg::*;
   ;
   logic              sys_clk;
   logic              rst_n;
   dcrv_reg_req_type  reg_req;
   logic [DATA_W-1:0] reg_rdata;
   logic              reg_rd_valid;
   logic              dynamic_range_compression_en;
   logic              sample_valid;
   dcrv_stereo_type   sample_in;
   dcrv_stereo_type   sample_out;
   logic              sample_out_valid;
   logic              left_power_up;
   logic              right_power_up;
   logic signed [15:0] out_l;
   logic signed [15:0] out_r;
   int                fails = 0;
   int                total_checks = 0;
   int                cycles = 0;
   logic signed [15:0] rl [4] = '{16'sh0, 16'sd1001, -16'sd2000, -16'sd500};
   logic signed [15:0] rr [4] = '{16'sh0, -16'sd2000, 16'sd1001, -16'sd500};
   logic [1:0]        lk [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
   logic [7:0]        lc [5] = '{8'h30, 8'he8, 8'h30, 8'h30, 8'h30};
   logic [7:0]        rc [5] = '{8'he8, 8'he8, 8'h30, 8'he8, 8'he8};

   dcrv_top i_dcrv_top (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid), .dynamic_range_compression_en(dynamic_range_compression_en),
      .sample_valid(sample_valid), .sample_in(sample_in), .sample_out(sample_out),
      .sample_out_valid(sample_out_valid), .left_power_up(left_power_up), .right_power_up(right_power_up));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic summarize();
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge sys_clk);
      reg_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
      @(negedge sys_clk);
      reg_req.wr_en = 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(negedge sys_clk);
      reg_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
      @(negedge sys_clk);
      reg_req.rd_en = 1'b0;
      check(16'(reg_rd_valid), 16'h1);
      check(16'(reg_rdata), 16'(exp));
   endtask

   task automatic snd(input logic signed [15:0] l, input logic signed [15:0] r);
      int n;
      @(negedge sys_clk);
      sample_in = '{left: l, right: r};
      sample_valid = 1'b1;
      @(negedge sys_clk);
      sample_valid = 1'b0;
      n = 0;
      while (sample_out_valid !== 1'b1 && n < 8) begin
         @(negedge sys_clk);
         n++;
      end
      check(16'(n < 8), 16'h1);
      out_l = sample_out.left;
      out_r = sample_out.right;
   endtask

   // Gain is a table approximation, so a 1.2 percent band plus two counts is allowed.
   task automatic near(input logic signed [15:0] seen, input real x, input logic [7:0] code);
      real e;
      real t;
      real s;
      s = seen;
      e = x * 10.0 ** ($itor($signed(code)) / 40.0);
      t = (e < 0.0 ? -e : e) * 0.012 + 2.0;
      check(16'(s - e <= t && e - s <= t), 16'h1);
   endtask

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         fails++;
         summarize();
      end
   end

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      reg_req = '0;
      dynamic_range_compression_en = 1'b0;
      sample_valid = 1'b0;
      sample_in = '0;
      rst_n = 1'b0;
      repeat (12) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      rd(ADDR_PATH_SETUP, 8'h14);
      rd(ADDR_MUTE_LINK, 8'h0c);
      rd(ADDR_LEFT_GAIN, 8'h00);
      rd(ADDR_RIGHT_GAIN, 8'h00);
      rd(7'h43, 8'h00);
      wr(ADDR_MUTE_LINK, 8'h03);
      rd(ADDR_MUTE_LINK, 8'h03);
      snd(16'sd1000, -16'sd2000);
      check(out_l, 16'h0);
      check(out_r, 16'h0);
      wr(ADDR_PATH_SETUP, 8'h94);
      snd(16'sd1000, -16'sd2000);
      check(out_l, 16'sd1000);
      check(out_r, 16'h0);
      $display("test reset and power finished");
      for (int s = 0; s < 4; s++) begin
         wr(ADDR_PATH_SETUP, 8'hc2 | 8'(s << 4) | 8'(s << 2));
         snd(16'sd1001, -16'sd2000);
         check(out_l, rl[s]);
         check(out_r, rr[s]);
      end
      wr(ADDR_PATH_SETUP, 8'hd6);
      wr(ADDR_MUTE_LINK, 8'h08);
      snd(16'sd1001, -16'sd2000);
      check(out_l, 16'h0);
      check(out_r, -16'sd2000);
      wr(ADDR_MUTE_LINK, 8'h04);
      snd(16'sd1001, -16'sd2000);
      check(out_l, 16'sd1001);
      check(out_r, 16'h0);
      $display("test routing and mute finished");
      wr(ADDR_LEFT_GAIN, 8'h81);
      wr(ADDR_MUTE_LINK, 8'h00);
      snd(16'sd30000, 16'sd0);
      near(out_l, 30000.0, 8'h81);
      wr(ADDR_LEFT_GAIN, 8'h30);
      wr(ADDR_RIGHT_GAIN, 8'he8);
      for (int k = 0; k < 5; k++) begin
         wr(ADDR_MUTE_LINK, 8'(lk[k]));
         dynamic_range_compression_en = (k == 4);
         snd(16'sd1000, -16'sd2000);
         near(out_l, 1000.0, lc[k]);
         near(out_r, -2000.0, rc[k]);
      end
      $display("test gain and link finished");
      dynamic_range_compression_en = 1'b0;
      wr(ADDR_MUTE_LINK, 8'h00);
      wr(ADDR_LEFT_GAIN, 8'h00);
      wr(ADDR_PATH_SETUP, 8'hd4);
      wr(ADDR_LEFT_GAIN, 8'h0c);
      repeat (6) snd(16'sd1000, -16'sd2000);
      check(16'(out_l > 16'sd1100 && out_l < 16'sd1900), 16'h1);
      repeat (7) snd(16'sd1000, -16'sd2000);
      near(out_l, 1000.0, 8'h0c);
      wr(ADDR_LEFT_GAIN, 8'h00);
      repeat (13) snd(16'sd1000, -16'sd2000);
      wr(ADDR_PATH_SETUP, 8'hd5);
      wr(ADDR_LEFT_GAIN, 8'h0c);
      repeat (13) snd(16'sd1000, -16'sd2000);
      check(16'(out_l > 16'sd900 && out_l < 16'sd1900), 16'h1);
      repeat (13) snd(16'sd1000, -16'sd2000);
      near(out_l, 1000.0, 8'h0c);
      $display("test soft stepping finished");
      summarize();
   end
endmodule

bind dcrv_top dcrv_top_sva i_dcrv_top_sva (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .dynamic_range_compression_en(dynamic_range_compression_en),
   .sample_valid(sample_valid), .sample_in(sample_in), .sample_out(sample_out),
   .sample_out_valid(sample_out_valid), .left_power_up(left_power_up), .right_power_up(right_power_up));
`default_nettype wire
